// File: core/cell_pkg.sv
// constants shared by the configurable logic cell: register map, fields, reset values, modes
// assumes a 32-bit ahb-lite bus with one word per register
package cell_pkg;
	// byte offsets of the register words
	localparam logic [7:0] OFF_CTRL_LOW = 8'h00;
	localparam logic [7:0] OFF_CTRL_HIGH = 8'h04;
	localparam logic [7:0] OFF_MUX_SELECT = 8'h08;
	localparam logic [7:0] OFF_GATE_EN_LOW = 8'h0c;
	localparam logic [7:0] OFF_GATE_EN_HIGH = 8'h10;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

	// cell_control_low fields and register write masks
	localparam int CTRL_EN_BIT = 15;
	localparam int CTRL_RISE_IRQ_BIT = 11;
	localparam int CTRL_FALL_IRQ_BIT = 10;
	localparam int CTRL_PIN_OE_BIT = 7;
	localparam int CTRL_OUT_STATE_BIT = 6;
	localparam int CTRL_OUT_INV_BIT = 5;
	localparam int CTRL_MODE_LSB = 0;
	localparam int MODE_W = 3;
	localparam logic [15:0] CTRL_LOW_WMASK = 16'h8ca7;
	localparam logic [15:0] CTRL_HIGH_WMASK = 16'h000f;
	localparam logic [15:0] MUX_SELECT_WMASK = 16'h7777;

	// selector fields and gate enable bytes
	localparam int SEL_FIELD_W = 3;
	localparam int SEL_FIELD_STRIDE = 4;
	localparam int SRC_PER_MUX = 8;
	localparam int EN_PER_GATE = 8;
	localparam logic [2:0] SRC_EXT = 3'h0;
	localparam logic [2:0] SRC_SYSCLK = 3'h1;

	// interrupt status and mask bits
	localparam int IRQ_RISE_BIT = 0;
	localparam int IRQ_FALL_BIT = 1;
	localparam int IRQ_W = 2;

	// reset values
	localparam logic [15:0] CTRL_LOW_RST = 16'h0000;
	localparam logic [15:0] CTRL_HIGH_RST = 16'h0000;
	localparam logic [15:0] MUX_SELECT_RST = 16'h0000;
	localparam logic [15:0] GATE_EN_RST = 16'h0000;
	localparam logic [1:0] IRQ_RST = 2'h0;

	typedef enum logic [2:0] {
		MODE_AND_OR = 3'h0,
		MODE_OR_XOR = 3'h1,
		MODE_AND4 = 3'h2,
		MODE_SR_LATCH = 3'h3,
		MODE_D_SR = 3'h4,
		MODE_D2_R = 3'h5,
		MODE_JK_R = 3'h6,
		MODE_LATCH_SR = 3'h7
	} cell_mode_e;
endpackage

// File: core/logic_cell.sv
// configurable logic cell top: ahb-lite register slave, source pool, output and interrupts
// assumes a single ahb-lite master, zero-wait writes and one wait state on every read
//
// Operation
// R1: four gates fed from 32-signal pool
// R2: each mux picks one of eight sources
// R3: selectors at bits 2:0,6:4,10:8,14:12
// R4: muxes give true and inverted copies, ORed
// R5: eight enables per gate, gates identical
// R6: high register bits 3:0 invert gates
// R7: modes 0-2: AND-OR, OR-XOR, AND
// R8: modes 3-7: latches and flip-flops
// R9: bit 5 inverts final output
// R10: bit 15 enables cell, else zero
// R11: bit 11 interrupts on rising output
// R12: bit 10 interrupts on falling output
// R13: bit 7 lets result drive pin
// R14: bit 6 reads current output level
// R15: output also offered to peripherals
// R16: high register bits 15:4 read zero
// R17: code 000 external inputs, 001 clock on first mux only
// R18: edges from previous-cycle sample, one pulse
// R19: storage modes use gates, system clock
module logic_cell (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic ext_input_a,
	input wire logic ext_input_b,
	input wire logic [31:0] periph_src,
	output logic periph_out,
	output logic pin_out,
	output logic pin_oe,
	output logic irq
);
	logic [15:0] ctrl_low_q;
	logic [15:0] ctrl_high_q;
	logic [15:0] mux_select_q;
	logic [15:0] gate_en_low_q;
	logic [15:0] gate_en_high_q;
	logic [1:0] irq_status_q;
	logic [1:0] irq_mask_q;
	logic wr_pend_q;
	logic rd_pend_q;
	logic [7:0] addr_q;
	logic [31:0] hrdata_q;
	logic out_q;
	logic out_prev_q;
	logic sysclk_image_q;
	logic [31:0] pool;
	logic [3:0] gate_out;
	logic func_out;
	logic cell_en;
	logic out_d;
	logic rise_ev;
	logic fall_ev;
	logic accept;
	logic status_read;

	// decode shared by the write path and the read path
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd, input logic [15:0] m);
		merge = (old & ~m) | (wd & m);
	endfunction

	// ---------------- bus slave ----------------
	assign accept = hsel & hready & htrans[1];
	assign hresp = 1'b0;
	assign hreadyout = ~rd_pend_q;
	assign hrdata = hrdata_q;
	assign status_read = rd_pend_q & hit(addr_q, cell_pkg::OFF_IRQ_STATUS);

	// reads take one wait state so a write just before them is already visible
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= 8'h00;
		end else begin
			if (wr_pend_q)
				wr_pend_q <= 1'b0;
			if (rd_pend_q)
				rd_pend_q <= 1'b0;
			if (accept) begin
				wr_pend_q <= hwrite;
				rd_pend_q <= ~hwrite;
				addr_q <= haddr[7:0] & 8'hfc;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (rd_pend_q) begin
			hrdata_q <= 32'h0000_0000;
			if (hit(addr_q, cell_pkg::OFF_CTRL_LOW))
				hrdata_q[15:0] <= ctrl_low_q;
			if (hit(addr_q, cell_pkg::OFF_CTRL_HIGH))
				hrdata_q[15:0] <= ctrl_high_q; // R16
			if (hit(addr_q, cell_pkg::OFF_MUX_SELECT))
				hrdata_q[15:0] <= mux_select_q;
			if (hit(addr_q, cell_pkg::OFF_GATE_EN_LOW))
				hrdata_q[15:0] <= gate_en_low_q;
			if (hit(addr_q, cell_pkg::OFF_GATE_EN_HIGH))
				hrdata_q[15:0] <= gate_en_high_q;
			if (hit(addr_q, cell_pkg::OFF_IRQ_STATUS))
				hrdata_q[1:0] <= irq_status_q;
			if (hit(addr_q, cell_pkg::OFF_IRQ_MASK))
				hrdata_q[1:0] <= irq_mask_q;
		end
	end

	// ---------------- configuration registers ----------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_low_q <= cell_pkg::CTRL_LOW_RST;
		end else begin
			if (wr_pend_q && hit(addr_q, cell_pkg::OFF_CTRL_LOW))
				ctrl_low_q <= merge(ctrl_low_q, hwdata[15:0], cell_pkg::CTRL_LOW_WMASK);
			ctrl_low_q[cell_pkg::CTRL_OUT_STATE_BIT] <= out_q; // R14
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_high_q <= cell_pkg::CTRL_HIGH_RST;
		end else if (wr_pend_q && hit(addr_q, cell_pkg::OFF_CTRL_HIGH)) begin
			ctrl_high_q <= merge(ctrl_high_q, hwdata[15:0], cell_pkg::CTRL_HIGH_WMASK); // R16
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mux_select_q <= cell_pkg::MUX_SELECT_RST;
		end else if (wr_pend_q && hit(addr_q, cell_pkg::OFF_MUX_SELECT)) begin
			mux_select_q <= merge(mux_select_q, hwdata[15:0], cell_pkg::MUX_SELECT_WMASK); // R3
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gate_en_low_q <= cell_pkg::GATE_EN_RST;
			gate_en_high_q <= cell_pkg::GATE_EN_RST;
		end else begin
			if (wr_pend_q && hit(addr_q, cell_pkg::OFF_GATE_EN_LOW))
				gate_en_low_q <= hwdata[15:0]; // R5
			if (wr_pend_q && hit(addr_q, cell_pkg::OFF_GATE_EN_HIGH))
				gate_en_high_q <= hwdata[15:0]; // R5
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_mask_q <= cell_pkg::IRQ_RST;
		end else if (wr_pend_q && hit(addr_q, cell_pkg::OFF_IRQ_MASK)) begin
			irq_mask_q <= hwdata[cell_pkg::IRQ_W-1:0];
		end
	end

	// ---------------- source pool ----------------
	// the clock cannot be used as data, so a half-rate image of it stands in for it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			sysclk_image_q <= 1'b0;
		else
			sysclk_image_q <= ~sysclk_image_q;
	end

	always_comb begin
		pool = periph_src;
		pool[0*cell_pkg::SRC_PER_MUX + int'(cell_pkg::SRC_EXT)] = ext_input_a; // R17
		pool[0*cell_pkg::SRC_PER_MUX + int'(cell_pkg::SRC_SYSCLK)] = sysclk_image_q; // R17
		pool[1*cell_pkg::SRC_PER_MUX + int'(cell_pkg::SRC_EXT)] = ext_input_b; // R17
		pool[2*cell_pkg::SRC_PER_MUX + int'(cell_pkg::SRC_EXT)] = ext_input_a; // R17
		pool[3*cell_pkg::SRC_PER_MUX + int'(cell_pkg::SRC_EXT)] = ext_input_b; // R17
	end

	source_gates u_gates (
		.pool(pool),
		.mux_select(mux_select_q),
		.gate_en_low(gate_en_low_q),
		.gate_en_high(gate_en_high_q),
		.gate_invert(ctrl_high_q[3:0]),
		.gate_out(gate_out)
	);

	assign cell_en = ctrl_low_q[cell_pkg::CTRL_EN_BIT];

	logic_function u_func (
		.hclk(hclk),
		.hresetn(hresetn),
		.enable(cell_en),
		.mode(ctrl_low_q[cell_pkg::CTRL_MODE_LSB +: cell_pkg::MODE_W]),
		.g(gate_out),
		.result(func_out)
	);

	// ---------------- output stage ----------------
	// disabled cell is zero after the polarity stage, so inversion cannot lift it
	assign out_d = cell_en & (func_out ^ ctrl_low_q[cell_pkg::CTRL_OUT_INV_BIT]); // R9 R10

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_q <= 1'b0;
			out_prev_q <= 1'b0;
		end else begin
			out_q <= out_d;
			out_prev_q <= out_q; // R18
		end
	end

	assign periph_out = out_q; // R15
	assign pin_oe = ctrl_low_q[cell_pkg::CTRL_PIN_OE_BIT]; // R13
	assign pin_out = pin_oe & out_q; // R13

	// ---------------- interrupts ----------------
	assign rise_ev = ctrl_low_q[cell_pkg::CTRL_RISE_IRQ_BIT] & out_q & ~out_prev_q; // R11 R18
	assign fall_ev = ctrl_low_q[cell_pkg::CTRL_FALL_IRQ_BIT] & ~out_q & out_prev_q; // R12 R18

	// a read clears the status, but an edge in the same cycle still lands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status_q <= cell_pkg::IRQ_RST;
		end else begin
			irq_status_q[cell_pkg::IRQ_RISE_BIT] <= rise_ev | (irq_status_q[cell_pkg::IRQ_RISE_BIT] & ~status_read);
			irq_status_q[cell_pkg::IRQ_FALL_BIT] <= fall_ev | (irq_status_q[cell_pkg::IRQ_FALL_BIT] & ~status_read);
		end
	end

	assign irq = |(irq_status_q & irq_mask_q);
endmodule

// File: core/logic_function.sv
// selectable logic function: three combinational forms, latches and flip-flops
// assumes gate inputs are synchronous; storage modes run on the system clock
module logic_function (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic enable,
	input wire logic [2:0] mode,
	input wire logic [3:0] g,
	output logic result
);
	logic state_q;
	logic state_d;
	logic clk_prev_q;
	logic clk_rise;
	logic set_in;
	logic rst_in;

	// role mapping: g[0] clock/enable, g[1] data/j, g[2] reset, g[3] set/k/second data; SR latch: g[0],g[1] set, g[2],g[3] reset
	assign clk_rise = g[0] & ~clk_prev_q; // R19
	assign set_in = g[3];
	assign rst_in = g[2];

	always_comb begin
		state_d = state_q;
		result = state_q;
		case (cell_pkg::cell_mode_e'(mode))
			cell_pkg::MODE_AND_OR: result = (g[0] & g[1]) | (g[2] & g[3]); // R7
			cell_pkg::MODE_OR_XOR: result = (g[0] | g[1]) ^ (g[2] | g[3]); // R7
			cell_pkg::MODE_AND4: result = &g; // R7
			cell_pkg::MODE_SR_LATCH: begin // R8
				// set dominates when both sides are asserted
				if (g[0] | g[1])
					state_d = 1'b1;
				else if (g[2] | g[3])
					state_d = 1'b0;
				result = state_d;
			end
			cell_pkg::MODE_D_SR: begin // R8
				if (rst_in)
					state_d = 1'b0;
				else if (set_in)
					state_d = 1'b1;
				else if (clk_rise)
					state_d = g[1];
			end
			cell_pkg::MODE_D2_R: begin // R8
				if (rst_in)
					state_d = 1'b0;
				else if (clk_rise)
					state_d = g[1] & g[3];
			end
			cell_pkg::MODE_JK_R: begin // R8
				if (rst_in)
					state_d = 1'b0;
				else if (clk_rise)
					state_d = (g[1] & ~state_q) | (~g[3] & state_q);
			end
			cell_pkg::MODE_LATCH_SR: begin // R8
				if (rst_in)
					state_d = 1'b0;
				else if (set_in)
					state_d = 1'b1;
				else if (g[0])
					state_d = g[1];
				result = state_d;
			end
			default: result = 1'b0;
		endcase
	end

	// flip-flop modes see their clock input only as sampled on hclk, so edges faster than hclk/2 are lost
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= 1'b0;
			clk_prev_q <= 1'b0;
		end else begin
			state_q <= enable ? state_d : 1'b0; // R19
			clk_prev_q <= g[0];
		end
	end
endmodule

// File: core/source_gates.sv
// four data-source multiplexers feeding four or-gates with polarity control
// assumes the 32-signal pool is already assembled and synchronous to the clock
module source_gates (
	input wire logic [31:0] pool,
	input wire logic [15:0] mux_select,
	input wire logic [15:0] gate_en_low,
	input wire logic [15:0] gate_en_high,
	input wire logic [3:0] gate_invert,
	output logic [3:0] gate_out
);
	logic [3:0] data;
	logic [7:0] pairs;
	logic [31:0] gate_en;

	assign gate_en = {gate_en_high, gate_en_low};

	genvar k;
	generate
		for (k = 0; k < 4; k++) begin : g_src
			logic [2:0] sel;
			logic [7:0] cand;
			assign sel = mux_select[k*cell_pkg::SEL_FIELD_STRIDE +: cell_pkg::SEL_FIELD_W]; // R3
			assign cand = pool[k*cell_pkg::SRC_PER_MUX +: cell_pkg::SRC_PER_MUX]; // R1
			assign data[k] = cand[sel]; // R2
			// even bit is the inverted copy, odd bit the true copy
			assign pairs[2*k] = ~data[k]; // R4
			assign pairs[2*k+1] = data[k];
		end
		for (k = 0; k < 4; k++) begin : g_gate
			logic [7:0] en;
			assign en = gate_en[k*cell_pkg::EN_PER_GATE +: cell_pkg::EN_PER_GATE];
			assign gate_out[k] = (|(en & pairs)) ^ gate_invert[k]; // R5 R6
		end
	endgenerate
endmodule

// File: dv/logic_cell_sva.sv
// port-level assertions for the configurable logic cell
// assumes hready is fed back from hreadyout and only single word transfers
module cell_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic periph_out,
	input wire logic pin_out,
	input wire logic pin_oe,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	logic acc_q;
	wire logic take = hsel && hready && htrans[1];
	// remembers a data phase, the only way software can move irq
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			acc_q <= 1'b0;
		else
			acc_q <= take;
	end
	bus_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
	read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
	write_nowait_a: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
	rdata_hold_a: assert property ($changed(hrdata) |-> !$past(hreadyout)) else $error("read data moved");
	unmapped_zero_a: assert property (take && !hwrite && haddr[7:2] > 6'h06 |=> ##1 hrdata == 32'h0)
		else $error("unmapped read not zero");
	upper_zero_a: assert property (take && !hwrite |=> ##1 hrdata[31:16] == 16'h0) else $error("upper half set");
	high_reg_a: assert property (take && !hwrite && haddr[7:0] == cell_pkg::OFF_CTRL_HIGH |=> ##1 hrdata[15:4] == 12'h0)
		else $error("reserved bits set");
	pin_gate_a: assert property (pin_out == (pin_oe && periph_out)) else $error("pin not gated");
	irq_rise_a: assert property ($rose(irq) |-> $past(periph_out) != $past(periph_out, 2) || $past(acc_q) || $past(acc_q, 2))
		else $error("irq rose without cause");
	irq_fall_a: assert property ($fell(irq) |-> $past(acc_q) || $past(acc_q, 2)) else $error("irq not sticky");
	cover property ($rose(irq));
	cover property ($rose(pin_out));
	cover property (take && !hwrite);
endmodule

bind logic_cell cell_checker i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.periph_out(periph_out), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));

// File: dv/periph_model.sv
// far side of the cell: pool peripherals and the two external inputs
// assumes the bench sets the wanted levels between edges
module periph_model (
	input wire logic hclk,
	input wire logic [31:0] pattern,
	input wire logic xa,
	input wire logic xb,
	output logic [31:0] periph_src,
	output logic ext_input_a,
	output logic ext_input_b
);
	timeunit 1ns;
	timeprecision 1ns;
	// all sources launch on the same edge, so no gate sees a half-changed pool
	always_ff @(posedge hclk) begin
		periph_src <= pattern;
		ext_input_a <= xa;
		ext_input_b <= xb;
	end
endmodule

// File: dv/tb.sv
// self-checking bench for the logic cell: ahb-lite register access and a random sweep of all modes
// assumes the design answers writes at once and reads after one wait state
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, xa = 1'b0, xb = 1'b0, pend = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, pat = 32'h0, hrdata, psrc;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, ina, inb, periph_out, pin_out, pin_oe, irq;
	logic [31:0] exp_q[$];
	int fails = 0, num_checks = 0;
	always #10 hclk = ~hclk;
	periph_model i_far (.hclk(hclk), .pattern(pat), .xa(xa), .xb(xb), .periph_src(psrc), .ext_input_a(ina),
		.ext_input_b(inb));
	logic_cell i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.ext_input_a(ina), .ext_input_b(inb), .periph_src(psrc), .periph_out(periph_out), .pin_out(pin_out),
		.pin_oe(pin_oe), .irq(irq));
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: read %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: output %h expected %h", $time, got, exp);
		end
	endtask
	// ready is judged mid-cycle; inputs only move at rising edges so it equals the edge value
	// no cycle count is assumed: only the watchdog ends a wait that never finishes
	task automatic wait_rdy();
		do begin
			@(negedge hclk);
		end while (hreadyout !== 1'b1);
		@(posedge hclk);
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		xfer(1'b1, a, {16'h0, d});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic chk_cell(input logic o, input logic e, input logic i);
		@(negedge hclk);
		chk_bit(periph_out, o);
		chk_bit(pin_out, o & e);
		chk_bit(irq, i);
		@(posedge hclk);
	endtask
	always @(negedge hclk) begin
		if (pend && hreadyout === 1'b1) begin
			pend = 1'b0;
			chk_word(hrdata, exp_q.pop_front());
		end
		if (hsel && htrans[1] && !hwrite && hreadyout === 1'b1)
			pend = 1'b1;
	end
	function automatic logic cell_next(input logic [2:0] m, input logic [3:0] g, input logic c0, input logic q);
		logic up;
		up = g[0] && !c0;
		case (m)
			3'h0: return (g[0] && g[1]) || (g[2] && g[3]);
			3'h1: return (g[0] || g[1]) ^ (g[2] || g[3]);
			3'h2: return &g;
			3'h3: return (g[0] || g[1]) ? 1'b1 : (g[2] || g[3]) ? 1'b0 : q;
			3'h4: return g[2] ? 1'b0 : g[3] ? 1'b1 : up ? g[1] : q;
			3'h5: return g[2] ? 1'b0 : up ? (g[1] && g[3]) : q;
			3'h6: return g[2] ? 1'b0 : up ? ((g[1] && !q) || (!g[3] && q)) : q;
			default: return g[2] ? 1'b0 : g[3] ? 1'b1 : g[0] ? g[1] : q;
		endcase
	endfunction
	initial begin
		#200us;
		fails++;
		wrap_up();
	end
	initial begin
		logic [31:0] pa, en;
		logic [3:0] inv, g, s;
		logic [2:0] c[4];
		logic [1:0] st, mk;
		logic [7:0] v;
		logic ea, eb, q, c0, prev, oi, oe, nmk;
		pa = $urandom(32'hd9a00903);
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int a = 0; a < 8; a++)
			rd(8'(a * 4), 32'h0);
		$display("test reset values done");
		wr(cell_pkg::OFF_CTRL_HIGH, 16'hffff);
		rd(cell_pkg::OFF_CTRL_HIGH, 32'h0000000f);
		wr(cell_pkg::OFF_MUX_SELECT, 16'hffff);
		rd(cell_pkg::OFF_MUX_SELECT, 32'h00007777);
		wr(cell_pkg::OFF_CTRL_LOW, 16'h7fff);
		rd(cell_pkg::OFF_CTRL_LOW, 32'h00000ca7);
		wr(cell_pkg::OFF_IRQ_MASK, 16'hffff);
		rd(cell_pkg::OFF_IRQ_MASK, 32'h00000003);
		$display("test register access done");
		prev = 1'b0;
		st = 2'h0;
		mk = 2'h3;
		for (int m = 0; m < 8; m++) begin
			inv = 4'($urandom());
			{oi, oe, nmk} = 3'($urandom());
			en = {24'($urandom()) & 24'hfcfcfc, 8'h02};
			for (int k = 0; k < 4; k++)
				c[k] = 3'($urandom());
			// gate 1 is the storage clock: keep it off the clock image, and keep mux 3 off the input it shares with mux 1
			if (c[0] == 3'h1)
				c[0] = 3'h2;
			if (c[2] == 3'h0)
				c[2] = 3'h1;
			wr(cell_pkg::OFF_CTRL_LOW, {1'b0, 3'h0, 2'h3, 2'h0, oe, 1'b0, oi, 2'h0, 3'(m)});
			repeat (3) @(posedge hclk);
			st[1] = st[1] | prev;
			prev = 1'b0;
			chk_cell(1'b0, oe, |(st & mk));
			mk = {1'b0, nmk} | 2'($urandom());
			wr(cell_pkg::OFF_IRQ_MASK, {14'h0, mk});
			wr(cell_pkg::OFF_CTRL_HIGH, {12'h0, inv});
			wr(cell_pkg::OFF_MUX_SELECT, {1'b0, c[3], 1'b0, c[2], 1'b0, c[1], 1'b0, c[0]});
			wr(cell_pkg::OFF_GATE_EN_LOW, en[15:0]);
			wr(cell_pkg::OFF_GATE_EN_HIGH, en[31:16]);
			pa = {24'($urandom()), {8{inv[0]}}};
			ea = inv[0];
			eb = 1'($urandom());
			q = 1'b0;
			c0 = 1'b0;
			for (int i = 0; i < 12; i++) begin
				if (i % 2 == 1) begin
					pa[7:0] = 8'($urandom());
					ea = 1'($urandom());
				end else if (i > 0) begin
					pa[31:8] = 24'($urandom());
					eb = 1'($urandom());
				end
				pat <= pa;
				xa <= ea;
				xb <= eb;
				if (i == 1)
					wr(cell_pkg::OFF_CTRL_LOW, {1'b1, 3'h0, 2'h3, 2'h0, oe, 1'b0, oi, 2'h0, 3'(m)});
				repeat (4) @(posedge hclk);
				for (int k = 0; k < 4; k++)
					s[k] = (c[k] == 3'h0) ? ((k % 2 == 0) ? ea : eb) : pa[8 * k + c[k]];
				v = {s[3], ~s[3], s[2], ~s[2], s[1], ~s[1], s[0], ~s[0]};
				for (int k = 0; k < 4; k++)
					g[k] = inv[k] ^ |(v & en[8 * k +: 8]);
				// gate 1 settles before the enable lands, so the first enabled step sees no clock edge
				if (i == 1)
					c0 = g[0];
				if (i > 0) begin
					q = cell_next(3'(m), g, c0, q);
					c0 = g[0];
					st = st | {prev & !(q ^ oi), !prev & (q ^ oi)};
					prev = q ^ oi;
				end
				chk_cell(prev, oe, |(st & mk));
			end
			rd(cell_pkg::OFF_CTRL_LOW, {16'h0, 1'b1, 3'h0, 2'h3, 2'h0, oe, prev, oi, 2'h0, 3'(m)});
			rd(cell_pkg::OFF_IRQ_STATUS, {30'h0, st});
			st = 2'h0;
			chk_cell(prev, oe, 1'b0);
			$display("test mode %0d done", m);
		end
		// clock source on mux 1 through gate 1 alone, or-xor mode: output must toggle every cycle
		wr(cell_pkg::OFF_CTRL_HIGH, 16'h0000);
		wr(cell_pkg::OFF_GATE_EN_HIGH, 16'h0000);
		wr(cell_pkg::OFF_GATE_EN_LOW, 16'h0002);
		wr(cell_pkg::OFF_MUX_SELECT, 16'h0001);
		wr(cell_pkg::OFF_CTRL_LOW, 16'h8001);
		repeat (3) @(posedge hclk);
		@(negedge hclk);
		q = periph_out;
		@(negedge hclk);
		chk_bit(periph_out ^ q, 1'b1);
		$display("test clock source done");
		wrap_up();
	end
endmodule
